//--- ecsc_pkg.sv
package ecsc_pkg;
   // Word width of the processor data bus
   localparam int unsigned DATA_W = 24;
   localparam int unsigned ADDR_W = 16;
   // First channel set and spacing between channel sets
   localparam logic [15:0] CHAN_BASE = 16'hc000;
   localparam logic [15:0] CHAN_STRIDE = 16'h0004;
   // Offsets within a channel set (X and Y halves share offset 0)
   localparam logic [1:0] OFS_STATUS = 2'h0;
   localparam logic [1:0] OFS_POS = 2'h1;
   localparam logic [1:0] OFS_CAPCMP = 2'h3;
   // Control field positions
   localparam int unsigned DECODE_LSB = 0;
   localparam int unsigned CAPSEL_LSB = 4;
   localparam int unsigned FLAGSEL_LSB = 8;
   localparam int unsigned CNTWR_BIT = 10;
   localparam int unsigned CMPLATCH_BIT = 11;
   localparam int unsigned CMPOE_BIT = 12;
   localparam int unsigned CMPINV_BIT = 13;
   localparam int unsigned AMPEN_BIT = 14;
   localparam int unsigned FILTDIS_BIT = 15;
   // Status field positions
   localparam int unsigned CMPEQ_BIT = 16;
   localparam int unsigned CAPT_BIT = 17;
   localparam int unsigned CNTERR_BIT = 18;
   localparam int unsigned INDEX_BIT = 19;
   localparam int unsigned HOME_BIT = 20;
   localparam int unsigned NLIM_BIT = 21;
   localparam int unsigned PLIM_BIT = 22;
   // Reset value of the control half
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   // Sample clock divider (system cycles per sample clock)
   localparam int unsigned SCLK_DIV = 2;
   // Decoder modes
   localparam logic [3:0] DEC_PD = 4'h0;
   localparam logic [3:0] DEC_X1 = 4'h1;
   localparam logic [3:0] DEC_X2 = 4'h2;
   localparam logic [3:0] DEC_X4 = 4'h3;

   // Encoder and switch inputs of one channel
   typedef struct packed {
      logic pha;
      logic phb;
      logic index;
      logic home;
      logic neg_lim;
      logic pos_lim;
   } ecsc_pins_type;

   // Processor bus request
   typedef struct packed {
      logic sel;
      logic wr;
      logic space_y;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } ecsc_bus_type;
endpackage : ecsc_pkg

//--- ecsc_input_sync.sv
`timescale 1ns/1ps
// Three-stage synchroniser with an agreement check on stages two and three
module ecsc_input_sync #(
   parameter int unsigned WIDTH = 6
) (
   input wire logic clock_i,            // System clock
   input wire logic rst_n_i,            // Async reset, active low
   input wire logic [WIDTH-1:0] async_i,// Raw pin levels
   output logic [WIDTH-1:0] sync_o      // Settled levels
);
   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;

   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi++)
      begin : g_bit
         // A change counts only once stages two and three agree
         always_ff @(posedge clock_i or negedge rst_n_i)
         begin
            if (!rst_n_i)
            begin
               s1_q[gi] <= 1'b0;
               s2_q[gi] <= 1'b0;
               s3_q[gi] <= 1'b0;
               sync_o[gi] <= 1'b0;
            end
            else
            begin
               s1_q[gi] <= async_i[gi];
               s2_q[gi] <= s1_q[gi];
               s3_q[gi] <= s2_q[gi];
               if (s2_q[gi] == s3_q[gi])
                  sync_o[gi] <= s3_q[gi];
            end
         end
      end
   endgenerate
endmodule : ecsc_input_sync

//--- ecsc_delay_filter.sv
`timescale 1ns/1ps
// Digital delay filter: output follows only after three equal samples
module ecsc_delay_filter (
   input wire logic clock_i,     // System clock
   input wire logic rst_n_i,     // Async reset, active low
   input wire logic sample_en_i, // Sample clock enable pulse
   input wire logic bypass_i,    // Filter disable
   input wire logic [1:0] in_i,  // Phase A and B
   output logic [1:0] out_o      // Filtered phases
);
   logic [1:0] h1_q;
   logic [1:0] h2_q;
   logic [1:0] filt_q;

   // Sample history; a glitch narrower than three samples never passes
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         h1_q <= 2'h0;
         h2_q <= 2'h0;
         filt_q <= 2'h0;
      end
      else if (sample_en_i)
      begin
         h1_q <= in_i;
         h2_q <= h1_q;
         for (int i = 0; i < 2; i++)
            if (in_i[i] == h1_q[i] && h1_q[i] == h2_q[i])
               filt_q[i] <= h2_q[i];
      end
   end

   // Bypass trades noise immunity for latency
   assign out_o = bypass_i ? in_i : filt_q;
endmodule : ecsc_delay_filter

//--- ecsc_channel.sv
`timescale 1ns/1ps
// Operation
// - Low 16 bits control, upper 8 read-only status
// - Decode, capture, flag select fields; capture flag
// - Count-write enable copies compare into counter
// - Compare flag latch, output enable, output invert
// - Amplifier enable pin follows control bit
// - Delay filter on encoder unless disabled
// - Count error latches, cleared by counter write
// - Index, home, limit levels in status bits
// - Interval between last two counts reported
// - Four channels, sets four addresses apart
// - Capture read-only, compare write-only, shared address
module ecsc_channel #(
   parameter int unsigned NUM_CHAN = 4,               // Channels per array
   parameter logic [15:0] BASE_ADDR = ecsc_pkg::CHAN_BASE, // Array base
   parameter int unsigned SCLK_DIV = ecsc_pkg::SCLK_DIV    // Sample divider
) (
   input wire logic clock_i,                            // 10 MHz clock
   input wire logic rst_n_i,                            // Async reset
   input wire ecsc_pkg::ecsc_bus_type bus_i,            // Processor request
   output logic [ecsc_pkg::DATA_W-1:0] rdata_o,         // Read data
   input wire ecsc_pkg::ecsc_pins_type [NUM_CHAN-1:0] pins_i, // Field pins
   output logic [NUM_CHAN-1:0] amp_enable_out_o,        // Amplifier enables
   output logic [NUM_CHAN-1:0] compare_match_out_o      // Compare outputs
);
   localparam int unsigned DW = ecsc_pkg::DATA_W;
   localparam int unsigned NP = 6;

   logic [7:0] div_q;
   logic sclk_en_q;
   logic [15:0] ctrl_q [NUM_CHAN];
   logic [DW-1:0] cnt_q [NUM_CHAN];
   logic [DW-1:0] cmp_q [NUM_CHAN];
   logic [DW-1:0] cap_q [NUM_CHAN];
   logic [DW-1:0] tmr_q [NUM_CHAN];
   logic [DW-1:0] ival_q [NUM_CHAN];
   logic [1:0] prev_q [NUM_CHAN];
   logic [NP-1:0] smp_q [NUM_CHAN];
   logic [NUM_CHAN-1:0] eq_q;
   logic [NUM_CHAN-1:0] cap_flag_q;
   logic [NUM_CHAN-1:0] err_q;
   logic [NUM_CHAN-1:0] cap_trig_prev_q;

   // Address decode: which channel and which word
   logic in_range;
   logic [15:0] rel;
   logic [1:0] ch_idx;
   logic [1:0] ofs;
   assign rel = bus_i.addr - BASE_ADDR;
   assign in_range = bus_i.sel &&
      (bus_i.addr >= BASE_ADDR) &&
      (rel < 16'(NUM_CHAN * 4));
   assign ch_idx = rel[3:2];
   assign ofs = rel[1:0];

   // Sample clock enable from a divider
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         div_q <= 8'h00;
         sclk_en_q <= 1'b0;
      end
      else if (div_q == 8'(SCLK_DIV - 1))
      begin
         div_q <= 8'h00;
         sclk_en_q <= 1'b1;
      end
      else
      begin
         div_q <= div_q + 8'h01;
         sclk_en_q <= 1'b0;
      end
   end

   genvar gc;
   generate
      for (gc = 0; gc < NUM_CHAN; gc++)
      begin : g_chan
         logic [NP-1:0] raw;
         logic [NP-1:0] sync;
         logic [1:0] ab;
         logic wr_here;
         logic wr_ctrl;
         logic wr_cnt;
         logic wr_cmp;
         logic clr_eq;
         logic step;
         logic up;
         logic illegal;
         logic [1:0] sel_flag;
         logic trig;
         logic eq_now;
         logic [3:0] dmode;

         assign raw = {pins_i[gc].pha, pins_i[gc].phb, pins_i[gc].index,
                       pins_i[gc].home, pins_i[gc].neg_lim,
                       pins_i[gc].pos_lim};

         ecsc_input_sync #(
            .WIDTH(NP)
         ) u_sync (
            .clock_i(clock_i),
            .rst_n_i(rst_n_i),
            .async_i(raw),
            .sync_o(sync)
         );

         // Filter bypassed when the disable bit is set
         ecsc_delay_filter u_filt (
            .clock_i(clock_i),
            .rst_n_i(rst_n_i),
            .sample_en_i(sclk_en_q),
            .bypass_i(ctrl_q[gc][ecsc_pkg::FILTDIS_BIT]),
            .in_i(sync[5:4]),
            .out_o(ab)
         );

         assign wr_here = in_range && bus_i.wr && (ch_idx == 2'(gc));
         assign wr_ctrl = wr_here && !bus_i.space_y &&
                          (ofs == ecsc_pkg::OFS_STATUS);
         assign wr_cnt = wr_here && (ofs == ecsc_pkg::OFS_POS);
         assign wr_cmp = wr_here && !bus_i.space_y &&
                         (ofs == ecsc_pkg::OFS_CAPCMP);
         assign clr_eq = wr_ctrl && bus_i.wdata[ecsc_pkg::CMPLATCH_BIT];
         assign dmode = ctrl_q[gc][ecsc_pkg::DECODE_LSB +: 4];

         // Quadrature decode: one gray step counts, two bits at once is illegal
         always_comb
         begin
            illegal = (ab[0] != prev_q[gc][0]) && (ab[1] != prev_q[gc][1]);
            up = ab[1] ^ prev_q[gc][0];
            unique case (dmode[1:0])
               ecsc_pkg::DEC_X1[1:0]:
                  step = ab[1] && !prev_q[gc][1] && !ab[0];
               ecsc_pkg::DEC_X2[1:0]:
                  step = ab[1] != prev_q[gc][1] && !illegal;
               ecsc_pkg::DEC_X4[1:0]:
                  step = (ab != prev_q[gc]) && !illegal;
               default:
                  step = ab[1] && !prev_q[gc][1];
            endcase
            if (dmode[1:0] == ecsc_pkg::DEC_PD[1:0])
               up = ab[0];
            if (dmode[2])
               up = !up;
         end

         // Flag select picks which input drives capture
         always_comb
         begin
            sel_flag = ctrl_q[gc][ecsc_pkg::FLAGSEL_LSB +: 2];
            unique case (sel_flag)
               2'h0: trig = sync[2];
               2'h1: trig = sync[3];
               2'h2: trig = sync[1];
               default: trig = sync[0];
            endcase
            if (ctrl_q[gc][ecsc_pkg::CAPSEL_LSB + 3])
               trig = !trig;
            trig = trig & (ctrl_q[gc][ecsc_pkg::CAPSEL_LSB +: 3] != 3'h0);
         end

         assign eq_now = (cnt_q[gc] == cmp_q[gc]);

         // Control half; status half ignores writes
         always_ff @(posedge clock_i or negedge rst_n_i)
         begin
            if (!rst_n_i)
               ctrl_q[gc] <= ecsc_pkg::CTRL_RESET;
            else if (wr_ctrl)
               ctrl_q[gc] <= bus_i.wdata[15:0];
         end

         // Position counter, with count-write from compare writes
         always_ff @(posedge clock_i or negedge rst_n_i)
         begin
            if (!rst_n_i)
               cnt_q[gc] <= '0;
            else if (wr_cmp && ctrl_q[gc][ecsc_pkg::CNTWR_BIT])
               cnt_q[gc] <= bus_i.wdata;
            else if (wr_cnt)
               cnt_q[gc] <= bus_i.wdata;
            else if (sclk_en_q && step)
               cnt_q[gc] <= up ? cnt_q[gc] + 24'h000001
                               : cnt_q[gc] - 24'h000001;
         end

         // Compare register, written only
         always_ff @(posedge clock_i or negedge rst_n_i)
         begin
            if (!rst_n_i)
               cmp_q[gc] <= '0;
            else if (wr_cmp)
               cmp_q[gc] <= bus_i.wdata;
         end

         // Sample-clock status: phases, capture, interval, flags
         always_ff @(posedge clock_i or negedge rst_n_i)
         begin
            if (!rst_n_i)
            begin
               prev_q[gc] <= 2'h0;
               smp_q[gc] <= '0;
               cap_q[gc] <= '0;
               cap_flag_q[gc] <= 1'b0;
               cap_trig_prev_q[gc] <= 1'b0;
               tmr_q[gc] <= '0;
               ival_q[gc] <= '0;
               eq_q[gc] <= 1'b0;
            end
            else if (sclk_en_q)
            begin
               prev_q[gc] <= ab;
               smp_q[gc] <= sync;
               cap_trig_prev_q[gc] <= trig;
               // Clear first so a capture on the same tick wins
               if (wr_ctrl)
                  cap_flag_q[gc] <= 1'b0;
               if (trig && !cap_trig_prev_q[gc])
               begin
                  cap_q[gc] <= cnt_q[gc];
                  cap_flag_q[gc] <= 1'b1;
               end
               // Saturate so the first count after a long stop reports the longest interval
               if (step)
               begin
                  ival_q[gc] <= tmr_q[gc];
                  tmr_q[gc] <= 24'h000001;
               end
               else if (tmr_q[gc] != '1)
                  tmr_q[gc] <= tmr_q[gc] + 24'h000001;
               // Latched mode holds the flag until a control write
               if (ctrl_q[gc][ecsc_pkg::CMPLATCH_BIT])
                  eq_q[gc] <= (eq_q[gc] & !clr_eq) | eq_now;
               else
                  eq_q[gc] <= eq_now;
            end
            else if (wr_ctrl)
            begin
               // A control write clears the capture flag, and the compare flag if it sets the latch bit
               cap_flag_q[gc] <= 1'b0;
               if (clr_eq)
                  eq_q[gc] <= 1'b0;
            end
         end

         // Count error: set wins over the counter-write clear
         always_ff @(posedge clock_i or negedge rst_n_i)
         begin
            if (!rst_n_i)
               err_q[gc] <= 1'b0;
            else if (sclk_en_q && illegal)
               err_q[gc] <= 1'b1;
            else if (wr_cnt || (wr_cmp && ctrl_q[gc][ecsc_pkg::CNTWR_BIT]))
               err_q[gc] <= 1'b0;
         end

         // Pins come straight from flip-flops
         always_ff @(posedge clock_i or negedge rst_n_i)
         begin
            if (!rst_n_i)
            begin
               amp_enable_out_o[gc] <= 1'b0;
               compare_match_out_o[gc] <= 1'b0;
            end
            else
            begin
               amp_enable_out_o[gc] <= ctrl_q[gc][ecsc_pkg::AMPEN_BIT];
               compare_match_out_o[gc] <= ctrl_q[gc][ecsc_pkg::CMPOE_BIT] &
                  (eq_q[gc] ^ ctrl_q[gc][ecsc_pkg::CMPINV_BIT]);
            end
         end
      end
   endgenerate

   // Read mux, registered; unmapped words read zero, the write-only compare word reads capture
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         rdata_o <= '0;
      else if (in_range && !bus_i.wr)
      begin
         rdata_o <= '0;
         unique case (ofs)
            ecsc_pkg::OFS_STATUS:
               if (bus_i.space_y)
                  rdata_o <= ival_q[ch_idx];
               else
                  rdata_o <= {1'b0, smp_q[ch_idx][0], smp_q[ch_idx][1],
                              smp_q[ch_idx][2], smp_q[ch_idx][3],
                              err_q[ch_idx], cap_flag_q[ch_idx],
                              eq_q[ch_idx], ctrl_q[ch_idx]};
            ecsc_pkg::OFS_POS:
               rdata_o <= cnt_q[ch_idx];
            ecsc_pkg::OFS_CAPCMP:
               rdata_o <= bus_i.space_y ? '0 : cap_q[ch_idx];
            default:
               rdata_o <= '0;
         endcase
      end
   end
endmodule : ecsc_channel

//--- ecsc_channel_chk.sv
`timescale 1ns/1ps
// Ties the channel outputs to the bus traffic through a control shadow
module ecsc_channel_chk #(
   parameter int unsigned NUM_CHAN = 4,
   parameter logic [15:0] BASE_ADDR = 16'hc000
) (
   input wire logic clock_i, // Clock
   input wire logic rst_n_i, // Async reset
   input wire ecsc_pkg::ecsc_bus_type bus_i, // Request
   input wire logic [ecsc_pkg::DATA_W-1:0] rdata_o, // Read data
   input wire ecsc_pkg::ecsc_pins_type [NUM_CHAN-1:0] pins_i, // Pins
   input wire logic [NUM_CHAN-1:0] amp_enable_out_o, // Amp enables
   input wire logic [NUM_CHAN-1:0] compare_match_out_o // Compare pins
);
   logic [15:0] ofs;
   logic hit;
   logic rd;
   logic rd_ctl;
   logic wr_ctl;
   logic [NUM_CHAN-1:0][15:0] ctl_q;
   logic [15:0] ctl_sel;
   logic [NUM_CHAN-1:0] amp_v;
   logic [NUM_CHAN-1:0] oe_v;
   logic [3:0] sw_v;
   // Request decode, limited to this array
   assign ofs = bus_i.addr - BASE_ADDR;
   assign hit = bus_i.sel && ofs < 16'(4 * NUM_CHAN);
   assign rd = hit && !bus_i.wr;
   assign rd_ctl = rd && !bus_i.space_y && ofs[1:0] == 2'h0;
   assign wr_ctl = hit && bus_i.wr && !bus_i.space_y && ofs[1:0] == 2'h0;
   assign ctl_sel = ctl_q[ofs[15:2]];
   assign sw_v = {pins_i[0].pos_lim, pins_i[0].neg_lim, pins_i[0].home,
                  pins_i[0].index};
   // Shadow of the writable halves; status bits are never stored
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         ctl_q <= '0;
      else if (wr_ctl)
         ctl_q[ofs[15:2]] <= bus_i.wdata[15:0];
   end
   // Per-channel enable bits pulled out of the shadow
   always_comb
   begin
      for (int i = 0; i < NUM_CHAN; i++)
      begin
         amp_v[i] = ctl_q[i][14];
         oe_v[i] = ctl_q[i][12];
      end
   end
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_wr0;
      wr_ctl && ofs == 16'h0000;
   endsequence
   sequence s_rd0;
      rd_ctl && ofs == 16'h0000;
   endsequence
   sequence s_quiet;
      $stable(pins_i[0]) [*8];
   endsequence
   a_amp_follows: assert property (amp_enable_out_o == $past(amp_v))
      else $error("amp enable differs from its control bit");
   a_cmp_gated: assert property (
      (compare_match_out_o & ~$past(oe_v)) == '0)
      else $error("compare pin driven while disabled");
   a_ctl_readback: assert property (s_wr0 ##1 s_rd0 |=>
      rdata_o[15:0] == $past(bus_i.wdata[15:0], 2))
      else $error("control readback differs from write");
   a_ctl_read: assert property (
      rd_ctl |=> rdata_o[15:0] == $past(ctl_sel))
      else $error("control read from wrong channel");
   a_top_zero: assert property (rd_ctl |=> !rdata_o[23])
      else $error("unused status bit reads one");
   a_gap_zero: assert property (rd && (ofs[1:0] == 2'h2 ||
      (bus_i.space_y && ofs[1:0] == 2'h3)) |=> rdata_o == '0)
      else $error("unmapped word reads nonzero");
   a_rdata_holds: assert property (!rd |=> $stable(rdata_o))
      else $error("read data moved without a read");
   a_pins_shown: assert property (s_quiet ##0 s_rd0 |=>
      rdata_o[22:19] == $past(sw_v))
      else $error("switch levels not shown in status");
endmodule : ecsc_channel_chk

bind ecsc_channel ecsc_channel_chk #(
   .NUM_CHAN(NUM_CHAN),
   .BASE_ADDR(BASE_ADDR)
) u_chk (
   .clock_i(clock_i),
   .rst_n_i(rst_n_i),
   .bus_i(bus_i),
   .rdata_o(rdata_o),
   .pins_i(pins_i),
   .amp_enable_out_o(amp_enable_out_o),
   .compare_match_out_o(compare_match_out_o)
);

//--- ecsc_field_model.sv
`timescale 1ns/1ps
// Quadrature encoder plus home and limit switches of one channel
module ecsc_field_model (
   input wire logic clock_i, // Clock
   input wire logic rst_n_i, // Async reset
   input wire logic fwd_i, // One count forward
   input wire logic rev_i, // One count back
   input wire logic jump_i, // Both phases at once
   input wire logic [3:0] sw_i, // Pos, neg, home, index
   output ecsc_pkg::ecsc_pins_type pins_o // Field pins
);
   logic [1:0] st_q;
   // Gray sequence; a jump of two states at once is the illegal move
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         st_q <= 2'h0;
      else if (jump_i)
         st_q <= st_q + 2'h2;
      else if (fwd_i)
         st_q <= st_q + 2'h1;
      else if (rev_i)
         st_q <= st_q - 2'h1;
   end
   // Switches are plain levels, no bounce modelled
   assign pins_o = '{pha: st_q[1], phb: st_q[1] ^ st_q[0],
                     index: sw_i[0], home: sw_i[1], neg_lim: sw_i[2],
                     pos_lim: sw_i[3]};
endmodule : ecsc_field_model

//--- encoder_channel_status_control_tb.sv
`timescale 1ns/1ps
module encoder_channel_status_control_tb;
   typedef struct packed {
      logic [23:0] mask;
      logic [23:0] lo;
      logic [23:0] hi;
   } ecsc_note_type;
   localparam logic [15:0] B = ecsc_pkg::CHAN_BASE;
   logic clock_i;
   logic rst_n_i;
   ecsc_pkg::ecsc_bus_type bus;
   ecsc_pkg::ecsc_pins_type p0;
   ecsc_pkg::ecsc_pins_type [2:0] prest;
   logic [23:0] rdata;
   logic [3:0] amp;
   logic [3:0] cmp;
   logic fwd;
   logic rev;
   logic jump;
   logic [3:0] sw;
   logic [23:0] v;
   ecsc_note_type notes[$];
   int error_cnt;
   int samples_checked;
   int cyc;

   ecsc_channel DUT (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .bus_i(bus),
      .rdata_o(rdata),
      .pins_i({prest, p0}),
      .amp_enable_out_o(amp),
      .compare_match_out_o(cmp)
   );
   ecsc_field_model u_field (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .fwd_i(fwd),
      .rev_i(rev),
      .jump_i(jump),
      .sw_i(sw),
      .pins_o(p0)
   );

   task automatic check(input string what, input logic [23:0] seen,
                        input logic [23:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic complete_run();
      if (error_cnt == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : complete_run

   // One request per edge; held until the next edge takes it
   task automatic acc(input logic w, input logic y, input logic [15:0] a,
                      input logic [23:0] d);
      @(posedge clock_i);
      #1;
      bus = '{sel: 1'b1, wr: w, space_y: y, addr: a, wdata: d};
   endtask : acc

   task automatic rd(input logic y, input logic [15:0] a,
                     input logic [23:0] m, lo, hi);
      notes.push_back('{m, lo, hi});
      acc(1'b0, y, a, 24'h000000);
   endtask : rd

   task automatic rde(input logic y, input logic [15:0] a,
                      input logic [23:0] m, e);
      rd(y, a, m, e, e);
   endtask : rde

   task automatic idle(input int n);
      @(posedge clock_i);
      #1;
      bus.sel = 1'b0;
      repeat (n) @(posedge clock_i);
   endtask : idle

   // Encoder move lasts one cycle; the bus goes quiet meanwhile
   task automatic move(input logic [2:0] k);
      @(posedge clock_i);
      #1;
      bus.sel = 1'b0;
      {jump, rev, fwd} = k;
      @(posedge clock_i);
      #1;
      {jump, rev, fwd} = 3'h0;
   endtask : move

   initial
   begin
      clock_i = 1'b0;
      forever #50 clock_i = ~clock_i;
   end

   // Hang guard, far above the length of the sequence
   always @(posedge clock_i)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         error_cnt++;
         complete_run();
      end
   end

   // Results land one edge after the request; compare them mid-cycle
   always
   begin : mon
      ecsc_note_type n;
      logic [23:0] s;
      logic [23:0] e;
      logic pend;
      @(posedge clock_i);
      pend = rst_n_i && bus.sel && !bus.wr && (bus.addr - B) < 16'h0010;
      @(negedge clock_i);
      if (pend)
      begin
         n = notes.pop_front();
         s = rdata & n.mask;
         e = (s >= n.lo && s <= n.hi) === 1'b1 ? s : n.lo;
         check("rdata", s, e);
      end
   end

   initial
   begin
      rst_n_i = 1'b0;
      bus = '0;
      {jump, rev, fwd} = 3'h0;
      sw = 4'h0;
      prest = '0;
      void'($urandom(32'h749016aa));
      repeat (3) @(posedge clock_i);
      #1;
      rst_n_i = 1'b1;
      // Clear controls after reset; unmapped words read zero
      for (int c = 0; c < 4; c++)
      begin
         rde(1'b0, B + 16'(4 * c), 24'h80ffff, 24'h0);
         rde(1'b0, B + 16'(4 * c + 2), 24'hffffff, 24'h0);
         rde(1'b1, B + 16'(4 * c + 3), 24'hffffff, 24'h0);
      end
      // Random controls, junk in the status byte must not stick
      for (int c = 0; c < 4; c++)
      begin
         v = 24'($urandom);
         acc(1'b1, 1'b0, B + 16'(4 * c), v);
         rde(1'b0, B + 16'(4 * c), 24'h80ffff, {8'h00, v[15:0]});
         idle(2);
         check("amp", 24'(amp[c]), 24'(v[14]));
      end
      // Y and out-of-range writes leave the controls alone
      acc(1'b1, 1'b1, B + 16'h000c, 24'hffffff);
      acc(1'b1, 1'b0, B + 16'h0010, 24'hffffff);
      rde(1'b0, B + 16'h000c, 24'h80ffff, {8'h00, v[15:0]});
      // Settled switch levels appear in the status bits
      repeat (3)
      begin
         sw = 4'($urandom);
         prest[0] = 6'($urandom);
         idle(10);
         rde(1'b0, B, 24'h780000, {1'b0, sw, 19'h0});
         rde(1'b0, B + 16'h0004, 24'h780000, {1'b0, prest[0].pos_lim,
             prest[0].neg_lim, prest[0].home, prest[0].index, 19'h0});
      end
      // Illegal move latches the error until the counter is written
      for (int f = 0; f < 2; f++)
      begin
         acc(1'b1, 1'b0, B, {8'h00, 1'(f), 15'h0003});
         move(3'h4);
         idle(10);
         rde(1'b0, B, 24'h040000, 24'h040000);
         acc(1'b1, 1'b0, B + 16'h0001, 24'h000000);
         rde(1'b0, B, 24'h040000, 24'h0);
         move(3'h1);
         idle(10);
         rde(1'b0, B, 24'h040000, 24'h0);
      end
      // A two-cycle double jump is a glitch: filtered, or an error if bypassed
      for (int f = 0; f < 2; f++)
      begin
         acc(1'b1, 1'b0, B, {8'h00, 1'(f), 15'h0003});
         acc(1'b1, 1'b0, B + 16'h0001, 24'h000000);
         move(3'h4);
         move(3'h4);
         idle(10);
         rde(1'b0, B, 24'h040000, {5'h00, 1'(f), 18'h0});
      end
      // Count-write copies the compare value; equality drives the pin
      v = 24'($urandom);
      acc(1'b1, 1'b0, B, 24'h000403);
      acc(1'b1, 1'b0, B + 16'h0003, v);
      rde(1'b0, B + 16'h0001, 24'hffffff, v);
      idle(6);
      rde(1'b0, B, 24'h010000, 24'h010000);
      acc(1'b1, 1'b0, B, 24'h001003);
      idle(6);
      check("match", 24'(cmp[0]), 24'h1);
      acc(1'b1, 1'b0, B, 24'h003003);
      idle(6);
      check("match", 24'(cmp[0]), 24'h0);
      acc(1'b1, 1'b0, B, 24'h000003);
      acc(1'b1, 1'b0, B + 16'h0003, v ^ 24'h000005);
      rde(1'b0, B + 16'h0001, 24'hffffff, v);
      idle(6);
      rde(1'b0, B, 24'h010000, 24'h0);
      // Latched mode keeps the flag; a write with the latch bit clears it
      acc(1'b1, 1'b0, B, 24'h000803);
      acc(1'b1, 1'b0, B + 16'h0003, v);
      idle(4);
      acc(1'b1, 1'b0, B + 16'h0003, v ^ 24'h000005);
      idle(6);
      rde(1'b0, B, 24'h010000, 24'h010000);
      acc(1'b1, 1'b0, B, 24'h000803);
      rde(1'b0, B, 24'h010000, 24'h0);
      // Rising home edge captures; a control write clears the flag
      sw = 4'h0;
      idle(10);
      acc(1'b1, 1'b0, B, 24'h000013);
      rde(1'b0, B, 24'h020000, 24'h0);
      sw = 4'h2;
      idle(10);
      rde(1'b0, B, 24'h020000, 24'h020000);
      rde(1'b0, B + 16'h0003, 24'hffffff, v);
      acc(1'b1, 1'b0, B, 24'h000013);
      rde(1'b0, B, 24'h020000, 24'h0);
      // Two counts 63 cycles apart give about 31 sample ticks
      acc(1'b1, 1'b0, B, 24'h008003);
      move(3'h1);
      idle(60);
      move(3'h2);
      idle(10);
      rd(1'b1, B, 24'hffffff, 24'h00001e, 24'h000021);
      // Opposite steps cancel, so the count is back where it was
      rde(1'b0, B + 16'h0001, 24'hffffff, v);
      idle(4);
      complete_run();
   end
endmodule : encoder_channel_status_control_tb
